// File: design/indexed_literal_offset_decode.sv
// core slice: extension decode, frame-relative addressing, apb register file
// assumes: standard apb master, one clock, registers written only while core is idle
//
// How it works
// RULE1 - subtract-and-return takes frame pointer minus 6-bit literal into frame pointer
// RULE2 - then program counter loads from top of return stack
// RULE3 - one word, two instruction cycles, second cycle does nothing
// RULE4 - pattern 1110 1001 11kkkkkk decodes as subtract-and-return on frame pointer
// RULE5 - extension enable also switches standard instructions to frame-relative offsets
// RULE6 - extension off: access bank when a=0, bank select register bank when a=1
// RULE7 - extension on, a=0, field at most 5Fh: frame pointer plus offset
// RULE8 - fields above 5Fh with a=0 keep access-bank addressing
// RULE9 - frame pointer 00h makes offsets land on direct access-bank locations
// RULE10 - destination bit keeps choosing working register or addressed byte
// RULE11 - indexed add sums working register and byte, updates N OV C DC Z
// RULE12 - add result to working register when d=0, to memory byte when d=1
// RULE13 - indexed bit set sets bit b of the byte, flags untouched
// RULE14 - indexed set-all writes FFh to the byte, flags untouched
// RULE15 - all formed addresses stay inside 000h to FFFh
// RULE16 - extension enable bit at 0 disables extension and indexed addressing
// RULE17 - effective address is frame pointer plus zero-extended offset, same cycle
`timescale 1ns/1ps
`default_nettype none
module indexed_literal_offset_decode
   import ilo_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // core state
   output logic coreBusy
);
   logic extEnable;
   logic [15:0] opcode;
   logic [11:0] framePtr;
   logic [7:0] workReg;
   logic [4:0] statusFlags;
   logic [3:0] bankSel;
   logic [20:0] progCnt;
   logic [20:0] topOfStack;
   logic [11:0] effAddr;
   logic [11:0] memAddrReg;
   logic memPend;
   logic [1:0] nopCnt;
   dec_t dec;
   core_state_t coreState;
   core_state_t next_coreState;
   wire memreq_t memReq;
   logic [7:0] memRdata;

   // opcode classification against the extension enable
   function automatic dec_t decodeInstr(input logic [15:0] op, input logic ext);
      dec_t d;
      d.isAdd = (op & ADD_MASK) == ADD_MATCH;
      d.isBsf = (op & BSF_MASK) == BSF_MATCH;
      d.isSetf = (op & SET_FILE_ALL_ONES_MASK) == SET_FILE_ALL_ONES_MATCH;
      // RULE4 subret pattern decode
      // RULE16 extension off leaves it unimplemented
      d.isSubRet = ext && ((op & SUBRET_MASK) == SUBRET_MATCH);
      d.dest = op[OP_DEST_BIT];
      d.access = op[OP_ACCESS_BIT];
      d.bitSel = op[11:9];
      d.field = op[7:0];
      return d;
   endfunction

   // data address from field, access bit, bank and frame pointer
   function automatic logic [11:0] formAddr(input logic [7:0] f, input logic a,
                                            input logic ext, input logic [11:0] fp,
                                            input logic [3:0] bank);
      logic [11:0] r;
      r = {bank, f};
      if (!a) begin
         if (ext && (f <= OFFSET_MAX)) begin
            r = fp + {4'h0, f};
         end else if (f <= OFFSET_MAX) begin
            r = {ACCESS_LO_BANK, f};
         end else begin
            r = {ACCESS_HI_BANK, f};
         end
      end
      return r;
   endfunction

   // decode and address selection
   wire dec_t decNow = decodeInstr(opcode, extEnable);
   // RULE5 extension steers standard addressing
   // RULE6 literal access or banked address
   // RULE7 frame-relative offset substitution
   // RULE8 high fields stay direct
   // RULE9 zero frame pointer maps direct
   // RULE15 twelve-bit address wraps in range
   // RULE17 frame plus zero-extended offset
   wire [11:0] addrNow = formAddr(decNow.field, decNow.access, extEnable, framePtr, bankSel);

   // alu on working register and fetched byte
   wire [8:0] addSum = {1'b0, workReg} + {1'b0, memRdata};
   wire [4:0] nibSum = {1'b0, workReg[3:0]} + {1'b0, memRdata[3:0]};
   wire [7:0] aluRes = addSum[7:0];
   wire addOv = (workReg[7] == memRdata[7]) && (addSum[7] != workReg[7]);
   wire [4:0] addFlags = {aluRes[7], addOv, aluRes == 8'h00, nibSum[4], addSum[8]};
   wire [7:0] bitMask = 8'h01 << dec.bitSel;
   wire inQ4 = coreState == C_Q4;
   wire [5:0] subLit = dec.field[5:0];

   // memory request: core in flight, else apb window
   wire apbTake = psel && penable && pready;
   wire apbWr = apbTake && pwrite;
   wire coreIdle = coreState == C_IDLE;
   // RULE10 destination bit chooses target
   // RULE12 add result back to memory when d=1
   wire coreMemWr = inQ4 && (dec.isBsf || dec.isSetf || (dec.isAdd && dec.dest));
   // RULE13 bit set data
   // RULE14 all ones data
   wire [7:0] coreWdata = dec.isSetf ? ALL_ONES :
                          dec.isBsf ? (memRdata | bitMask) : aluRes;
   assign memReq.we = coreMemWr || (apbWr && paddr == OFS_MDATA);
   assign memReq.addr = coreIdle ? memAddrReg : effAddr;
   assign memReq.wdata = coreMemWr ? coreWdata : pwdata[7:0];

   ilo_data_mem #(.AW(DMEM_AW), .DW(DMEM_DW)) ilo_data_mem_i (
      .clk(sys_clk),
      .we(memReq.we),
      .addr(memReq.addr),
      .wdata(memReq.wdata),
      .rdata(memRdata)
   );

   // apb read mux and decode
   wire mapped = paddr inside {OFS_CTRL, OFS_INSTR, OFS_FRAME, OFS_WORK, OFS_STATUS,
                               OFS_BANK, OFS_PC, OFS_TOS, OFS_EADDR, OFS_MADDR, OFS_MDATA};
   wire [31:0] rdMux =
      (paddr == OFS_CTRL) ? {31'h0, extEnable} :
      (paddr == OFS_INSTR) ? {16'h0, opcode} :
      (paddr == OFS_FRAME) ? {20'h0, framePtr} :
      (paddr == OFS_WORK) ? {24'h0, workReg} :
      (paddr == OFS_STATUS) ? {23'h0, coreBusy, 3'h0, statusFlags} :
      (paddr == OFS_BANK) ? {28'h0, bankSel} :
      (paddr == OFS_PC) ? {11'h0, progCnt} :
      (paddr == OFS_TOS) ? {11'h0, topOfStack} :
      (paddr == OFS_EADDR) ? {20'h0, effAddr} :
      (paddr == OFS_MADDR) ? {20'h0, memAddrReg} :
      (paddr == OFS_MDATA) ? {24'h0, memRdata} : 32'h0;
   wire apbWait = psel && penable && !pready;
   wire mdataRd = !pwrite && paddr == OFS_MDATA;

   // apb answer: held off while the core runs, one extra cycle for memory reads
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0;
         memPend <= 1'b0;
      end else begin
         pready <= 1'b0;
         if (apbWait && coreIdle && mdataRd && !memPend) begin
            memPend <= 1'b1;
         end else if (apbWait && coreIdle) begin
            memPend <= 1'b0;
            pready <= 1'b1;
            pslverr <= !mapped;
            prdata <= (pwrite || !mapped) ? 32'h0 : rdMux;
         end
      end
   end

   // software-written configuration
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         extEnable <= 1'b0;
         bankSel <= 4'h0;
         topOfStack <= 21'h0;
         memAddrReg <= 12'h000;
      end else if (apbWr) begin
         // RULE16 enable bit written by software
         if (paddr == OFS_CTRL) extEnable <= pwdata[CTRL_EXT_BIT];
         if (paddr == OFS_BANK) bankSel <= pwdata[3:0];
         if (paddr == OFS_TOS) topOfStack <= pwdata[PC_W-1:0];
         if (paddr == OFS_MADDR) memAddrReg <= pwdata[DMEM_AW-1:0];
      end
   end

   // sequencer: q1 decode, q2 read, q3 process, q4 write, optional nop cycle
   always_comb begin
      next_coreState = coreState;
      case (coreState)
         C_IDLE: if (apbWr && paddr == OFS_INSTR) next_coreState = C_Q1;
         C_Q1: next_coreState = C_Q2;
         C_Q2: next_coreState = C_Q3;
         C_Q3: next_coreState = C_Q4;
         // RULE3 second cycle for subtract-and-return
         C_Q4: next_coreState = dec.isSubRet ? C_NOP : C_IDLE;
         C_NOP: if (nopCnt == NOP_LAST) next_coreState = C_IDLE;
         default: next_coreState = C_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         coreState <= C_IDLE;
         coreBusy <= 1'b0;
         nopCnt <= 2'h0;
         opcode <= 16'h0000;
         dec <= '0;
         effAddr <= 12'h000;
      end else begin
         coreState <= next_coreState;
         coreBusy <= next_coreState != C_IDLE;
         nopCnt <= (coreState == C_NOP) ? nopCnt + 2'h1 : 2'h0;
         if (coreIdle && apbWr && paddr == OFS_INSTR) opcode <= pwdata[15:0];
         if (coreState == C_Q1) begin
            dec <= decNow;
            effAddr <= addrNow;
         end
      end
   end

   // architectural state written in q4 or by software while idle
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         framePtr <= FRAME_RST;
         workReg <= 8'h00;
         statusFlags <= 5'h00;
         progCnt <= 21'h0;
      end else if (inQ4) begin
         if (dec.isSubRet) begin
            // RULE1 frame pointer minus literal
            framePtr <= framePtr - {6'h00, subLit};
            // RULE2 return from top of stack
            progCnt <= topOfStack;
         end else begin
            progCnt <= progCnt + PC_STEP;
         end
         if (dec.isAdd) begin
            // RULE11 add flags
            statusFlags <= addFlags;
            // RULE12 add result to working register
            if (!dec.dest) workReg <= aluRes;
         end
      end else if (apbWr) begin
         if (paddr == OFS_FRAME) framePtr <= pwdata[DMEM_AW-1:0];
         if (paddr == OFS_WORK) workReg <= pwdata[7:0];
         if (paddr == OFS_STATUS) statusFlags <= pwdata[4:0];
         if (paddr == OFS_PC) progCnt <= pwdata[PC_W-1:0];
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   a_subret_frame_sub: assert property (inQ4 && dec.isSubRet |=> // RULE1
      framePtr == $past(framePtr) - {6'h00, $past(subLit)})
      else $error("frame pointer not reduced by literal");
   a_subret_pc_load: assert property (inQ4 && dec.isSubRet |=> // RULE2
      progCnt == $past(topOfStack))
      else $error("return did not load top of stack");
   a_subret_nop_cycle: assert property (inQ4 && dec.isSubRet |=> // RULE3
      (coreState == C_NOP && coreBusy) [*4] ##1 coreState == C_IDLE)
      else $error("second cycle not four nop phases");
   a_subret_decode: assert property (coreState == C_Q1 && extEnable && // RULE4
      opcode[15:6] == 10'h3A7 |=> dec.isSubRet)
      else $error("subtract-and-return not decoded");
   a_ext_off_plain: assert property (coreState == C_Q1 && !extEnable // RULE16
      |=> !dec.isSubRet && effAddr == (dec.access ? {bankSel, dec.field} :
          {(dec.field > OFFSET_MAX) ? ACCESS_HI_BANK : ACCESS_LO_BANK, dec.field}))
      else $error("literal addressing wrong with extension off");
   a_indexed_addr: assert property (coreState == C_Q1 && extEnable && // RULE7
      !opcode[OP_ACCESS_BIT] && opcode[7:0] <= OFFSET_MAX
      |=> effAddr == $past(framePtr) + {4'h0, dec.field})
      else $error("indexed address not frame plus offset");
   a_high_direct: assert property (coreState == C_Q1 && extEnable && // RULE8
      !opcode[OP_ACCESS_BIT] && opcode[7:0] > OFFSET_MAX
      |=> effAddr == {ACCESS_HI_BANK, dec.field})
      else $error("high field not access bank");
   a_add_to_work: assert property (inQ4 && dec.isAdd && !dec.dest |=> // RULE12
      workReg == $past(aluRes) && statusFlags == $past(addFlags))
      else $error("add result not in working register");
   a_bitset_write: assert property (inQ4 && dec.isBsf |-> memReq.we && // RULE13
      memReq.addr == effAddr && memReq.wdata == (memRdata | bitMask)
      ##1 $stable(statusFlags))
      else $error("bit set write wrong");
   a_setall_write: assert property (inQ4 && dec.isSetf |-> memReq.we && // RULE14
      memReq.wdata == ALL_ONES ##1 $stable(statusFlags))
      else $error("set-all write wrong");
   a_zero_frame_direct: assert property (coreState == C_Q1 && extEnable && // RULE9
      framePtr == 12'h000 && !opcode[OP_ACCESS_BIT] |=> effAddr ==
      {(dec.field > OFFSET_MAX) ? ACCESS_HI_BANK : ACCESS_LO_BANK, dec.field})
      else $error("zero frame pointer not direct");
   a_dest_keeps_work: assert property (inQ4 && dec.isAdd && dec.dest |=> // RULE10
      $stable(workReg))
      else $error("working register changed with d=1");
   a_nop_cycle_idle: assert property (coreState == C_NOP |-> !memReq.we ##1 // RULE3
      $stable(framePtr) && $stable(progCnt) && $stable(workReg) && $stable(statusFlags))
      else $error("second cycle not a no-operation");
endmodule
`default_nettype wire

// File: design/ilo_pkg.sv
// package: register map, opcode patterns, field positions and types for the indexed decode core
// assumes: imported by the core and its testbench, one 200 MHz clock
package ilo_pkg;
   // apb byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_INSTR = 8'h04;
   localparam logic [7:0] OFS_FRAME = 8'h08;
   localparam logic [7:0] OFS_WORK = 8'h0C;
   localparam logic [7:0] OFS_STATUS = 8'h10;
   localparam logic [7:0] OFS_BANK = 8'h14;
   localparam logic [7:0] OFS_PC = 8'h18;
   localparam logic [7:0] OFS_TOS = 8'h1C;
   localparam logic [7:0] OFS_EADDR = 8'h20;
   localparam logic [7:0] OFS_MADDR = 8'h24;
   localparam logic [7:0] OFS_MDATA = 8'h28;
   // field positions
   localparam int CTRL_EXT_BIT = 0;
   localparam int ST_C = 0;
   localparam int ST_DC = 1;
   localparam int ST_Z = 2;
   localparam int ST_OV = 3;
   localparam int ST_N = 4;
   localparam int ST_BUSY = 8;
   localparam int OP_DEST_BIT = 9;
   localparam int OP_ACCESS_BIT = 8;
   // widths and reset values
   localparam int DMEM_AW = 12;
   localparam int DMEM_DW = 8;
   localparam int PC_W = 21;
   localparam logic [11:0] FRAME_RST = 12'h000;
   localparam logic [20:0] PC_STEP = 21'h000002;
   localparam logic [7:0] ALL_ONES = 8'hFF;
   localparam logic [7:0] OFFSET_MAX = 8'h5F;
   localparam logic [3:0] ACCESS_HI_BANK = 4'hF;
   localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
   localparam logic [1:0] NOP_LAST = 2'h3;
   // opcode patterns
   localparam logic [15:0] SUBRET_MASK = 16'hFFC0;
   localparam logic [15:0] SUBRET_MATCH = 16'hE9C0;
   localparam logic [15:0] ADD_MASK = 16'hFC00;
   localparam logic [15:0] ADD_MATCH = 16'h2400;
   localparam logic [15:0] BSF_MASK = 16'hF000;
   localparam logic [15:0] BSF_MATCH = 16'h8000;
   localparam logic [15:0] SET_FILE_ALL_ONES_MASK = 16'hFE00;
   localparam logic [15:0] SET_FILE_ALL_ONES_MATCH = 16'h6800;

   typedef struct packed {
      logic isAdd;
      logic isBsf;
      logic isSetf;
      logic isSubRet;
      logic dest;
      logic access;
      logic [2:0] bitSel;
      logic [7:0] field;
   } dec_t;

   typedef struct packed {
      logic we;
      logic [11:0] addr;
      logic [7:0] wdata;
   } memreq_t;

   typedef enum logic [2:0] {C_IDLE, C_Q1, C_Q2, C_Q3, C_Q4, C_NOP} core_state_t;
endpackage

// File: design/ilo_data_mem.sv
// data memory: 4096 bytes, one port, registered read data
// assumes: address and write request stable for the cycle they are sampled
`timescale 1ns/1ps
`default_nettype none
module ilo_data_mem #(
   parameter int AW = 12,
   parameter int DW = 8
) (
   // clock
   input wire logic clk,
   // port
   input wire logic we,
   input wire logic [AW-1:0] addr,
   input wire logic [DW-1:0] wdata,
   output logic [DW-1:0] rdata
);
   logic [DW-1:0] store [0:(1<<AW)-1];

   always_ff @(posedge clk) begin
      if (we) begin
         store[addr] <= wdata;
      end
      rdata <= store[addr];
   end
endmodule
`default_nettype wire

// File: bench/indexed_literal_offset_decode_test.sv
// testbench: apb register tasks, instruction issue and result checks for the decode core
// assumes: apb slave timing and register map of the core, one 200 MHz clock
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin testsRun++; if ((got) !== (exp)) begin badCount++; \
   $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp); end end
module indexed_literal_offset_decode_test;
   import ilo_pkg::*;
   typedef struct packed {
      logic ext;
      logic [11:0] frame;
      logic [15:0] op;
      logic [11:0] ea;
   } ea_case_t;
   logic sys_clk;
   logic rst_n;
   logic psel;
   logic penable;
   logic pwrite;
   logic [7:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic coreBusy;
   logic [31:0] rd;
   logic err;
   int badCount = 0;
   int testsRun = 0;
   int busyN;
   ea_case_t cases [7] = '{
      '{1'b0, 12'hA00, 16'h6820, 12'h020},
      '{1'b0, 12'hA00, 16'h6910, 12'h310},
      '{1'b1, 12'hA00, 16'h6860, 12'hF60},
      '{1'b1, 12'h000, 16'h6820, 12'h020},
      '{1'b1, 12'hFF0, 16'h6820, 12'h010},
      '{1'b1, 12'hA00, 16'h685F, 12'hA5F},
      '{1'b1, 12'hA00, 16'h6910, 12'h310}};

   always #2.5 sys_clk = ~sys_clk;

   indexed_literal_offset_decode indexed_literal_offset_decode_i (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .coreBusy(coreBusy)
   );

   task automatic giveVerdict();
      if (badCount == 0 && testsRun > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // one apb transfer, held until pready is seen at a rising edge
   task automatic apbXfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                          output logic [31:0] rdata, output logic slverr);
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= wdata;
      @(posedge sys_clk);
      penable <= 1'b1;
      do begin
         @(posedge sys_clk);
      end while (pready !== 1'b1);
      rdata = prdata;
      slverr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      logic e;
      apbXfer(1'b1, a, d, x, e);
   endtask

   task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] x;
      logic e;
      apbXfer(1'b0, a, 32'h0, x, e);
      `CHK({e, x}, {1'b0, exp})
   endtask

   task automatic memSet(input logic [11:0] a, input logic [7:0] d);
      wr(OFS_MADDR, {20'h0, a});
      wr(OFS_MDATA, {24'h0, d});
   endtask

   task automatic memChk(input logic [11:0] a, input logic [7:0] d);
      wr(OFS_MADDR, {20'h0, a});
      rdChk(OFS_MDATA, {24'h0, d});
   endtask

   // issue an opcode and count the cycles the core reports busy
   task automatic issue(input logic [15:0] op);
      wr(OFS_INSTR, {16'h0, op});
      busyN = 0;
      repeat (12) begin
         @(posedge sys_clk);
         if (coreBusy === 1'b1) busyN++;
      end
   endtask

   initial begin
      sys_clk = 1'b0;
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (3) @(posedge sys_clk);
      rst_n <= 1'b1;
      rdChk(OFS_CTRL, 32'h0);
      rdChk(OFS_FRAME, 32'h0);
      rdChk(OFS_STATUS, 32'h0);
      apbXfer(1'b0, 8'h40, 32'h0, rd, err);
      `CHK({err, rd}, 33'h100000000)
      // extension off: direct access-bank add into memory
      wr(OFS_FRAME, 32'hA00);
      memSet(12'h020, 8'h10);
      wr(OFS_WORK, 32'h05);
      issue(16'h2620);
      memChk(12'h020, 8'h15);
      rdChk(OFS_PC, 32'h2);
      `CHK(busyN, 4)
      // extension on: indexed add into working register
      wr(OFS_CTRL, 32'h1);
      memSet(12'hA2C, 8'h20);
      wr(OFS_WORK, 32'h17);
      issue(16'h242C);
      rdChk(OFS_WORK, 32'h37);
      memChk(12'hA2C, 8'h20);
      rdChk(OFS_EADDR, 32'hA2C);
      rdChk(OFS_STATUS, 32'h0);
      // carry, zero and overflow together
      memSet(12'hA30, 8'h80);
      wr(OFS_WORK, 32'h80);
      issue(16'h2630);
      memChk(12'hA30, 8'h00);
      rdChk(OFS_WORK, 32'h80);
      rdChk(OFS_STATUS, 32'h0D);
      // indexed bit set, flags kept
      memSet(12'hA0A, 8'h55);
      issue(16'h8E0A);
      memChk(12'hA0A, 8'hD5);
      rdChk(OFS_STATUS, 32'h0D);
      // indexed set-all, flags kept
      issue(16'h682C);
      memChk(12'hA2C, 8'hFF);
      rdChk(OFS_STATUS, 32'h0D);
      // effective address table
      wr(OFS_BANK, 32'h3);
      foreach (cases[i]) begin
         wr(OFS_CTRL, {31'h0, cases[i].ext});
         wr(OFS_FRAME, {20'h0, cases[i].frame});
         issue(cases[i].op);
         rdChk(OFS_EADDR, {20'h0, cases[i].ea});
      end
      // subtract-and-return
      wr(OFS_CTRL, 32'h1);
      wr(OFS_FRAME, 32'h3FF);
      wr(OFS_TOS, 32'h100);
      issue(16'hE9E3);
      `CHK(busyN, 8)
      rdChk(OFS_FRAME, 32'h3DC);
      rdChk(OFS_PC, 32'h100);
      // other pointer select does not touch the frame pointer
      issue(16'hE9A3);
      rdChk(OFS_FRAME, 32'h3DC);
      rdChk(OFS_PC, 32'h102);
      // extension off: no subtract-and-return
      wr(OFS_CTRL, 32'h0);
      issue(16'hE9E3);
      rdChk(OFS_FRAME, 32'h3DC);
      rdChk(OFS_PC, 32'h104);
      giveVerdict();
   end

   // watchdog: the run needs a few hundred cycles
   initial begin
      #100000;
      badCount++;
      giveVerdict();
   end
endmodule
`default_nettype wire
